/* File: design/dma_channel_arbitration_control.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_channel_arbitration_control
  import dma_arb_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port.
  input  wire reg_req_t    reg_i,
  output logic [15:0]      rdata,
  // Peripheral trigger lines, same clock.
  input  wire logic [7:0]  trig_in,
  // Memory side of the transfer engine.
  output mem_req_t         mem_o,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  // CPU bus arbitration.
  input  wire logic        cpu_req,
  input  wire class_t      cpu_target,
  output logic             cpu_grant,
  // Events and configuration.
  output logic [3:0]       transfer_end_interrupt,
  output logic [7:0]       system_wait_control
);

  typedef struct packed {
    chan_t [3:0] ch;
    phase_t      ph;
    logic [1:0]  cur;
    logic [15:0] data;
    logic [15:0] rdata;
    logic [7:0]  wait_cfg;
    logic [3:0]  end_pulse;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [3:0] eligible;
  logic       win_valid;
  logic [1:0] win_idx;
  class_t     cls_src;
  class_t     cls_dst;
  logic       busy;

  // Address map of the bus targets, by the two top address bits.
  function automatic class_t target_class(input logic [25:0] a);
    return class_t'(a[25:24]);
  endfunction : target_class

  function automatic logic [25:0] step_addr(input logic [25:0] a,
                                            input logic [1:0]  dir,
                                            input logic        wide);
    logic [25:0] inc;
    inc = wide ? 26'h0000002 : 26'h0000001;
    if (dir == DIR_INC) begin
      return a + inc;
    end else if (dir == DIR_DEC) begin
      return a - inc;
    end
    return a;
  endfunction : step_addr

  function automatic logic [25:0] align(input logic [25:0] a,
                                        input logic        wide);
    return wide ? {a[25:1], 1'b0} : a;
  endfunction : align

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      eligible[i] = st_ff.ch[i].pend && st_ff.ch[i].en && !st_ff.ch[i].tc;
    end
  end

  dma_prio_pick u_pick (
    .req   (eligible),
    .valid (win_valid),
    .idx   (win_idx)
  );

  assign busy    = st_ff.ph != PH_IDLE;
  assign cls_src = target_class(st_ff.ch[st_ff.cur].src);
  assign cls_dst = target_class(st_ff.ch[st_ff.cur].dst);

  // The CPU only sees the bus between transfer cycles, except for ROM and RAM
  // during an EXT/IO transfer and ROM during an IO/RAM transfer.
  always_comb begin
    logic xfer_cycle;
    logic ext_io;
    logic io_ram;
    xfer_cycle = st_ff.ph inside {PH_READ, PH_GAP, PH_WRITE};
    ext_io = (cls_src == CLS_EXT && cls_dst == CLS_IO)
          || (cls_src == CLS_IO && cls_dst == CLS_EXT);
    io_ram = (cls_src == CLS_IO && cls_dst == CLS_RAM)
          || (cls_src == CLS_RAM && cls_dst == CLS_IO);
    cpu_grant = 1'b0;
    if (st_ff.ph == PH_REL || (st_ff.ph == PH_IDLE && !win_valid)) begin
      cpu_grant = cpu_req;
    end else if (xfer_cycle) begin
      if (ext_io && (cpu_target == CLS_ROM || cpu_target == CLS_RAM)) begin
        cpu_grant = cpu_req;
      end else if (io_ram && cpu_target == CLS_ROM) begin
        cpu_grant = cpu_req;
      end
    end
  end

  always_comb begin
    mem_o       = '0;
    mem_o.req   = st_ff.ph == PH_READ || st_ff.ph == PH_WRITE;
    mem_o.we    = st_ff.ph == PH_WRITE;
    mem_o.wide  = st_ff.ch[st_ff.cur].wide;
    mem_o.addr  = align(st_ff.ph == PH_WRITE ? st_ff.ch[st_ff.cur].dst
                                             : st_ff.ch[st_ff.cur].src,
                        st_ff.ch[st_ff.cur].wide);
    mem_o.wdata = st_ff.data;
  end

  always_comb begin
    logic [1:0]  rch;
    logic [2:0]  ridx;
    logic        hit;
    logic        raw;
    logic        sel;
    logic [2:0]  tsel;
    logic        active;
    logic        taken;
    raw              = 1'b0;
    sel              = 1'b0;
    tsel             = 3'h0;
    active           = 1'b0;
    taken            = 1'b0;
    nxt_st           = st_ff;
    nxt_st.rdata     = 16'h0000;
    nxt_st.end_pulse = 4'h0;
    rch  = reg_i.addr[4:3];
    ridx = reg_i.addr[2:0];
    hit  = !reg_i.addr[5];

    // Register writes; are left to software.
    if (reg_i.wr && reg_i.addr == IDX_SYSWAIT) begin
      nxt_st.wait_cfg = reg_i.wdata[7:0];
    end
    if (reg_i.wr && hit) begin
      unique case (ridx)
        IDX_SRC_LO: nxt_st.ch[rch].src[15:0]  = reg_i.wdata;
        IDX_SRC_HI: nxt_st.ch[rch].src[25:16] = reg_i.wdata[HI_BITS-1:0];
        IDX_DST_LO: nxt_st.ch[rch].dst[15:0]  = reg_i.wdata;
        IDX_DST_HI: nxt_st.ch[rch].dst[25:16] = reg_i.wdata[HI_BITS-1:0];
        IDX_COUNT: begin
          nxt_st.ch[rch].remain        = reg_i.wdata;
          nxt_st.ch[rch].initial_count = reg_i.wdata;
        end
        IDX_ADC: begin
          nxt_st.ch[rch].wide = reg_i.wdata[ADC_WIDE];
          nxt_st.ch[rch].sdir = reg_i.wdata[ADC_SDIR +: 2];
          nxt_st.ch[rch].ddir = reg_i.wdata[ADC_DDIR +: 2];
        end
        IDX_CTRL: begin
          nxt_st.ch[rch].en = reg_i.wdata[CTRL_EN];
          // An initialize aimed at the channel on the bus is lost; software
          // retries and checks the count to see that it took.
          if (reg_i.wdata[CTRL_INIT] && !(busy && st_ff.cur == rch)) begin
            nxt_st.ch[rch].en     = 1'b0;
            nxt_st.ch[rch].tc     = 1'b0;
            nxt_st.ch[rch].pend   = 1'b0;
            nxt_st.ch[rch].remain = st_ff.ch[rch].initial_count;
          end
        end
        IDX_TRIG: nxt_st.ch[rch].factor = reg_i.wdata[5:0];
      endcase
    end

    // Register reads; answer stands one cycle after the strobe.
    if (reg_i.rd && reg_i.addr == IDX_SYSWAIT) begin
      nxt_st.rdata = {8'h00, st_ff.wait_cfg};
    end
    if (reg_i.rd && hit) begin
      unique case (ridx)
        IDX_SRC_LO: nxt_st.rdata = st_ff.ch[rch].src[15:0];
        IDX_SRC_HI: nxt_st.rdata = {6'h00, st_ff.ch[rch].src[25:16]};
        IDX_DST_LO: nxt_st.rdata = st_ff.ch[rch].dst[15:0];
        IDX_DST_HI: nxt_st.rdata = {6'h00, st_ff.ch[rch].dst[25:16]};
        IDX_COUNT:  nxt_st.rdata = st_ff.ch[rch].remain;
        IDX_ADC: begin
          nxt_st.rdata[ADC_WIDE]       = st_ff.ch[rch].wide;
          nxt_st.rdata[ADC_SDIR +: 2]  = st_ff.ch[rch].sdir;
          nxt_st.rdata[ADC_DDIR +: 2]  = st_ff.ch[rch].ddir;
        end
        IDX_CTRL: begin
          nxt_st.rdata[CTRL_EN] = st_ff.ch[rch].en;
          nxt_st.rdata[CTRL_TC] = st_ff.ch[rch].tc;
          // Any read, including the read half of a bit instruction, clears
          // the flag; a terminal count landing later in this cycle wins.
          nxt_st.ch[rch].tc = 1'b0;
        end
        IDX_TRIG: begin
          nxt_st.rdata[5:0]       = st_ff.ch[rch].factor;
          nxt_st.rdata[TRIG_PEND] = st_ff.ch[rch].pend;
        end
      endcase
    end

    // Request capture per channel.
    for (int i = 0; i < 4; i++) begin
      tsel   = 3'(st_ff.ch[i].factor - 6'h01);
      sel    = (st_ff.ch[i].factor != 6'h00) && trig_in[tsel];
      nxt_st.ch[i].trig_prev = sel;
      raw    = (sel && !st_ff.ch[i].trig_prev)
            || (reg_i.wr && hit && ridx == IDX_CTRL && rch == 2'(i)
                && reg_i.wdata[CTRL_SWTRG]);
      active = busy && st_ff.cur == 2'(i);
      taken  = st_ff.ph == PH_IDLE && win_valid && win_idx == 2'(i);
      if (raw && !active && !taken && !st_ff.ch[i].pend
          && nxt_st.ch[i].en && !nxt_st.ch[i].tc) begin
        nxt_st.ch[i].pend = 1'b1;
      end
    end

    // Transfer engine: one read, one idle clock, one write, then release.
    unique case (st_ff.ph)
      PH_IDLE: begin
        if (win_valid) begin
          nxt_st.cur               = win_idx;
          nxt_st.ch[win_idx].pend  = 1'b0;
          nxt_st.ph                = PH_READ;
        end
      end
      PH_READ: begin
        if (mem_ack) begin
          nxt_st.data = mem_rdata;
          nxt_st.ph   = PH_GAP;
        end
      end
      PH_GAP: nxt_st.ph = PH_WRITE;
      PH_WRITE: begin
        if (mem_ack) begin
          nxt_st.ch[st_ff.cur].src = step_addr(st_ff.ch[st_ff.cur].src,
            st_ff.ch[st_ff.cur].sdir, st_ff.ch[st_ff.cur].wide);
          nxt_st.ch[st_ff.cur].dst = step_addr(st_ff.ch[st_ff.cur].dst,
            st_ff.ch[st_ff.cur].ddir, st_ff.ch[st_ff.cur].wide);
          nxt_st.ch[st_ff.cur].remain = st_ff.ch[st_ff.cur].remain - 16'h0001;
          if (st_ff.ch[st_ff.cur].remain == 16'h0001) begin
            nxt_st.ch[st_ff.cur].en     = 1'b0;
            nxt_st.ch[st_ff.cur].tc     = 1'b1;
            nxt_st.ch[st_ff.cur].remain = st_ff.ch[st_ff.cur].initial_count;
            nxt_st.end_pulse[st_ff.cur] = 1'b1;
          end
          nxt_st.ph = PH_REL;
        end
      end
      PH_REL: nxt_st.ph = PH_IDLE;
      default: nxt_st.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff          <= '0;
      st_ff.wait_cfg <= SYSWAIT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata                  = st_ff.rdata;
  assign transfer_end_interrupt = st_ff.end_pulse;
  assign system_wait_control    = st_ff.wait_cfg;

endmodule : dma_channel_arbitration_control
`default_nettype wire

/* File: design/dma_arb_pkg.sv */
package dma_arb_pkg;
  // Register index inside a channel block; byte address = 4 * full index.
  localparam logic [2:0] IDX_SRC_LO  = 3'h0;
  localparam logic [2:0] IDX_SRC_HI  = 3'h1;
  localparam logic [2:0] IDX_DST_LO  = 3'h2;
  localparam logic [2:0] IDX_DST_HI  = 3'h3;
  localparam logic [2:0] IDX_COUNT   = 3'h4;
  localparam logic [2:0] IDX_ADC     = 3'h5;
  localparam logic [2:0] IDX_CTRL    = 3'h6;
  localparam logic [2:0] IDX_TRIG    = 3'h7;
  localparam logic [5:0] IDX_SYSWAIT = 6'h20;
  localparam logic [7:0] SYSWAIT_RST = 8'h77;
  // Field positions.
  localparam int CTRL_EN    = 0;
  localparam int CTRL_SWTRG = 1;
  localparam int CTRL_INIT  = 2;
  localparam int CTRL_TC    = 7;
  localparam int ADC_WIDE   = 14;
  localparam int ADC_SDIR   = 6;
  localparam int ADC_DDIR   = 4;
  localparam int TRIG_PEND  = 7;
  localparam int HI_BITS    = 10;
  localparam logic [1:0] DIR_INC = 2'h0;
  localparam logic [1:0] DIR_DEC = 2'h1;
  localparam logic [1:0] DIR_FIX = 2'h2;

  typedef enum logic [1:0] {
    CLS_ROM = 2'b00, CLS_RAM = 2'b01, CLS_EXT = 2'b10, CLS_IO = 2'b11
  } class_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_READ = 3'b001, PH_GAP = 3'b010,
    PH_WRITE = 3'b011, PH_REL = 3'b100
  } phase_t;

  typedef struct packed {
    logic [25:0] src;
    logic [25:0] dst;
    logic [15:0] remain;
    logic [15:0] initial_count;
    logic        wide;
    logic [1:0]  sdir;
    logic [1:0]  ddir;
    logic        en;
    logic        tc;
    logic [5:0]  factor;
    logic        pend;
    logic        trig_prev;
  } chan_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        wide;
    logic [25:0] addr;
    logic [15:0] wdata;
  } mem_req_t;
endpackage : dma_arb_pkg

/* File: design/dma_prio_pick.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_prio_pick
  import dma_arb_pkg::*;
(
  // Requests, channel 0 in bit 0.
  input  wire logic [3:0] req,
  // Winner.
  output logic            valid,
  output logic [1:0]      idx
);
  always_comb begin
    valid = |req;
    idx   = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        idx = 2'(i);
      end
    end
  end
endmodule : dma_prio_pick
`default_nettype wire

/* File: test/dma_arb_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_arb_chk
  import dma_arb_pkg::*;
(
  // Clock and reset.
  input wire logic       clock,
  input wire logic       rst,
  // Observed outputs and inputs.
  input wire mem_req_t   mem_o,
  input wire logic       mem_ack,
  input wire logic       cpu_req,
  input wire class_t     cpu_target,
  input wire logic       cpu_grant,
  input wire logic [3:0] transfer_end_interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence rd_done;
    mem_o.req && !mem_o.we && mem_ack;
  endsequence
  sequence wr_done;
    mem_o.req && mem_o.we && mem_ack;
  endsequence
  a_req_stands: assert property (
    mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o))
    else $error("transfer request changed before ack");
  a_wide_even: assert property (
    mem_o.req && mem_o.wide |-> !mem_o.addr[0])
    else $error("halfword address is odd");
  a_read_gap: assert property (
    rd_done |=> !mem_o.req ##1 (mem_o.req && mem_o.we))
    else $error("no single idle cycle before write");
  a_bus_release: assert property (
    wr_done |=> !mem_o.req && (cpu_grant == cpu_req))
    else $error("bus not released after write");
  a_ext_waits: assert property (
    mem_o.req && cpu_target == CLS_EXT |-> !cpu_grant)
    else $error("external access granted during transfer");
  a_grant_asked: assert property (
    !cpu_req |-> !cpu_grant)
    else $error("grant without request");
  a_end_pulse: assert property (
    |transfer_end_interrupt |=> transfer_end_interrupt == 4'h0)
    else $error("end interrupt longer than one cycle");
  a_end_cause: assert property (
    |transfer_end_interrupt |-> $past(mem_ack) && $past(mem_o.we))
    else $error("end interrupt without write ack");
endmodule : dma_arb_chk
`default_nettype wire

/* File: test/mem_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_partner
  import dma_arb_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Access port.
  input  wire mem_req_t    mem_o,
  input  wire logic [1:0]  lat,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack
);
  logic [1:0]  wait_ff;
  logic [15:0] churn_ff;
  // Data outside the ack cycle keeps changing so a late sample cannot pass.
  assign mem_ack   = mem_o.req && (wait_ff == lat);
  assign mem_rdata = mem_ack ? mem_o.addr[15:0] : churn_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_ff  <= 2'h0;
      churn_ff <= 16'h0;
    end else begin
      wait_ff  <= (mem_o.req && !mem_ack) ? wait_ff + 2'h1 : 2'h0;
      churn_ff <= churn_ff + 16'h3A5D;
    end
  end
endmodule : mem_partner
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dma_arb_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  reg_req_t    reg_i = '0;
  logic [15:0] rdata, mem_rdata;
  logic [7:0]  trig_in = 8'h00;
  logic [7:0]  system_wait_control;
  mem_req_t    mem_o;
  logic        mem_ack, cpu_grant;
  logic        cpu_req = 1'b0;
  class_t      cpu_target = CLS_ROM;
  logic [3:0]  transfer_end_interrupt;
  logic [3:0]  ints = 4'h0;
  logic [1:0]  lat = 2'h0;
  logic [25:0] rlog[$];
  int          num_errors = 0;
  int          samples_checked = 0;
  always #10 clock = ~clock;
  dma_channel_arbitration_control u_dma_channel_arbitration_control (
    .clock(clock), .rst(rst), .reg_i(reg_i), .rdata(rdata),
    .trig_in(trig_in), .mem_o(mem_o), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .cpu_req(cpu_req), .cpu_target(cpu_target),
    .cpu_grant(cpu_grant), .transfer_end_interrupt(transfer_end_interrupt),
    .system_wait_control(system_wait_control));
  mem_partner u_mem_partner (.clock(clock), .rst(rst), .mem_o(mem_o),
    .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // Sampled mid-cycle so the combinational request has settled.
  always @(negedge clock) begin
    if (mem_o.req && mem_ack && !mem_o.we) rlog.push_back(mem_o.addr);
    ints <= ints | transfer_end_interrupt;
  end
  function automatic logic [5:0] ra(input logic [1:0] ch, input logic [2:0] r);
    return {1'b0, ch, r};
  endfunction : ra
  // Source low is odd on purpose; a halfword access must clear bit zero.
  function automatic logic [25:0] sa(input logic [1:0] ch);
    return {10'h200, 8'h00, ch, 6'h00};
  endfunction : sa
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock) reg_i <= '{1'b1, 1'b0, a, d};
    @(posedge clock) reg_i <= '0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clock) reg_i <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clock) reg_i <= '0;
    #1 chk(26'(rdata), 26'(exp));
  endtask : rd
  task automatic setup(input logic [1:0] ch, input logic [15:0] cnt);
    wr(ra(ch, IDX_SRC_LO), {8'h00, ch, 6'h01});
    wr(ra(ch, IDX_SRC_HI), 16'h0200);
    wr(ra(ch, IDX_DST_HI), 16'h0300);
    wr(ra(ch, IDX_ADC), 16'h40A0);
    wr(ra(ch, IDX_COUNT), cnt);
    wr(ra(ch, IDX_TRIG), {14'h0000, ch} + 16'h0001);
    wr(ra(ch, IDX_CTRL), 16'h0001);
  endtask : setup
  task automatic wreads(input int n);
    for (int i = 0; i < 300 && rlog.size() < n; i++) @(posedge clock);
    repeat (20) @(posedge clock);
    chk(26'(rlog.size()), 26'(n));
  endtask : wreads
  task automatic wreq;
    for (int i = 0; i < 50 && mem_o.req !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
  endtask : wreq
  task automatic s_reset;
    chk(26'(system_wait_control), 26'h77);
    rd(6'h21, 16'h0000);
    wr(IDX_SYSWAIT, 16'h0012);
    #1 chk(26'(system_wait_control), 26'h12);
  endtask : s_reset
  task automatic s_drop;
    lat <= 2'h3;
    rlog.delete();
    @(posedge clock) trig_in <= 8'h01;
    wreq();
    @(posedge clock) trig_in <= 8'h00;
    @(posedge clock) trig_in <= 8'h03;
    wreads(2);
    chk(rlog[0], sa(2'd0));
    chk(rlog[1], sa(2'd1));
    @(posedge clock) trig_in <= 8'h00;
  endtask : s_drop
  task automatic s_prio;
    lat <= 2'h0;
    rlog.delete();
    @(posedge clock) trig_in <= 8'h0F;
    rd(ra(2'd3, IDX_TRIG), 16'h0084);
    wreads(4);
    for (int i = 0; i < 4; i++) chk(rlog[i], sa(i[1:0]));
    rd(ra(2'd3, IDX_TRIG), 16'h0004);
    @(posedge clock) trig_in <= 8'h00;
  endtask : s_prio
  task automatic s_pause;
    rlog.delete();
    wr(ra(2'd2, IDX_CTRL), 16'h0000);
    wr(ra(2'd2, IDX_CTRL), 16'h0000);
    @(posedge clock) trig_in <= 8'h04;
    repeat (20) @(posedge clock);
    chk(26'(rlog.size()), 26'h0);
    @(posedge clock) trig_in <= 8'h00;
    wr(ra(2'd2, IDX_CTRL), 16'h0001);
    @(posedge clock) trig_in <= 8'h04;
    wreads(1);
    rd(ra(2'd2, IDX_COUNT), 16'h0002);
    wr(ra(2'd2, IDX_CTRL), 16'h0004);
    rd(ra(2'd2, IDX_COUNT), 16'h0004);
    rd(ra(2'd2, IDX_CTRL), 16'h0000);
    @(posedge clock) trig_in <= 8'h00;
  endtask : s_pause
  task automatic s_end;
    wr(ra(2'd0, IDX_CTRL), 16'h0004);
    setup(2'd0, 16'h0001);
    rlog.delete();
    lat        <= 2'h3;
    cpu_req    <= 1'b1;
    cpu_target <= CLS_EXT;
    wr(ra(2'd0, IDX_CTRL), 16'h0003);
    wreq();
    chk(26'(cpu_grant), 26'h0);
    @(posedge clock) cpu_target <= CLS_RAM;
    #1 chk(26'(cpu_grant), 26'h1);
    wreads(1);
    chk(rlog[0], sa(2'd0));
    chk(26'(ints[0]), 26'h1);
    rd(ra(2'd0, IDX_CTRL), 16'h0080);
    rd(ra(2'd0, IDX_CTRL), 16'h0000);
    rd(ra(2'd0, IDX_CTRL), 16'h0000);
    rd(ra(2'd0, IDX_CTRL), 16'h0000);
    @(posedge clock) cpu_req <= 1'b0;
  endtask : s_end
  task automatic summarize;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // The whole run needs well under two thousand cycles; the limit of 10000 cycles leaves ample margin.
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    s_reset();
    for (int c = 0; c < 4; c++) setup(c[1:0], 16'h0004);
    s_drop();
    s_prio();
    s_pause();
    s_end();
    summarize();
  end
endmodule : tb_top
bind dma_channel_arbitration_control dma_arb_chk u_dma_arb_chk (
  .clock(clock), .rst(rst), .mem_o(mem_o), .mem_ack(mem_ack),
  .cpu_req(cpu_req), .cpu_target(cpu_target), .cpu_grant(cpu_grant),
  .transfer_end_interrupt(transfer_end_interrupt));
`default_nettype wire
